// ### src/sys_control2_pgood_filter.sv
// Second system control register with power-good deglitch, frequency, soft stop, current limit
`timescale 1ns/100ps
`include "sys_ctrl2_defs.svh"
module sys_control2_pgood_filter #(
  parameter int CW = 12,
  parameter int RW = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic en_pin,
  input wire logic sw_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic over_voltage_trip,
  input wire logic under_voltage_trip,
  output logic power_good_output,
  output logic [15:0] on_time_cyc,
  output logic [1:0] freq_code,
  output sys_ctrl2_pkg::ilim_sel_t ilim_sel,
  output logic converter_on,
  output logic bus_active,
  output logic discharge_active,
  output logic output_floating,
  output logic [RW-1:0] ramp_level
);
  // ==========================================
  // Reset release
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================
  // State
  typedef struct packed {
    sys_ctrl2_pkg::ctrl2_fields_t fields;
    logic [7:0] rdata;
    logic rvalid;
    sys_ctrl2_pkg::stop_state_t stop;
    logic [15:0] step_cnt;
    logic [RW-1:0] level;
    logic [15:0] ton;
  } top_state_t;
  top_state_t st_reg;
  top_state_t st_next;
  logic run_req;
  logic bus_on;
  logic [CW-1:0] delay_cyc;
  logic raw_good;

  assign bus_on = en_pin;
  assign run_req = en_pin && sw_enable;
  assign raw_good = !(over_voltage_trip || under_voltage_trip);

  always_comb
  begin
    unique case (st_reg.fields.filt_code)
      2'b00: delay_cyc = CW'(`SC2_DLY0_CYC);
      2'b01: delay_cyc = CW'(`SC2_DLY1_CYC);
      2'b10: delay_cyc = CW'(`SC2_DLY2_CYC);
      2'b11: delay_cyc = CW'(`SC2_DLY3_CYC);
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    if (bus_on && reg_wr && reg_addr == `SC2_OFFSET)
    begin
      st_next.fields = reg_wdata;
    end
    if (bus_on && reg_rd)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = (reg_addr == `SC2_OFFSET) ? st_reg.fields : 8'h00;
    end
    unique case (st_reg.fields.freq_code)
      2'b00: st_next.ton = `SC2_TON_500K;
      2'b01: st_next.ton = `SC2_TON_750K;
      2'b10: st_next.ton = `SC2_TON_1M;
      2'b11: st_next.ton = `SC2_TON_1M25;
    endcase
    unique case (st_reg.stop)
      sys_ctrl2_pkg::ST_RUN:
      begin
        st_next.level = '1;
        if (!run_req)
        begin
          st_next.step_cnt = 16'h0000;
          st_next.stop = st_reg.fields.soft_stop ? sys_ctrl2_pkg::ST_RAMP
                                                 : sys_ctrl2_pkg::ST_OFF;
        end
      end
      sys_ctrl2_pkg::ST_RAMP:
      begin
        if (run_req)
        begin
          st_next.stop = sys_ctrl2_pkg::ST_RUN;
        end
        else if (st_reg.level == '0)
        begin
          st_next.stop = sys_ctrl2_pkg::ST_OFF;
        end
        else if (st_reg.step_cnt + 16'h0001 >= `SC2_STOP_STEP)
        begin
          st_next.step_cnt = 16'h0000;
          st_next.level = st_reg.level - RW'(1);
        end
        else
        begin
          st_next.step_cnt = st_reg.step_cnt + 16'h0001;
        end
      end
      sys_ctrl2_pkg::ST_OFF:
      begin
        st_next.level = '0;
        if (run_req)
        begin
          st_next.stop = sys_ctrl2_pkg::ST_RUN;
        end
      end
      default:
      begin
        st_next.stop = sys_ctrl2_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.fields <= `SC2_RESET;
      st_reg.stop <= sys_ctrl2_pkg::ST_OFF;
      st_reg.ton <= `SC2_TON_500K;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Power-good deglitch
  good_flag_filter #(.CW(CW)) u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw_in(raw_good),
    .delay_cyc(delay_cyc),
    .filt_out(power_good_output)
  );

  // ==========================================
  // Outputs
  assign reg_rdata = st_reg.rdata;
  assign reg_rvalid = st_reg.rvalid;
  assign on_time_cyc = st_reg.ton;
  assign freq_code = st_reg.fields.freq_code;
  assign ilim_sel = '{peak_en: 1'b1, valley_en: 1'b1, code: st_reg.fields.ilim_code};
  assign converter_on = (st_reg.stop == sys_ctrl2_pkg::ST_RUN);
  assign bus_active = bus_on;
  assign discharge_active = (st_reg.stop == sys_ctrl2_pkg::ST_RAMP);
  assign output_floating = (st_reg.stop == sys_ctrl2_pkg::ST_OFF) && !st_reg.fields.soft_stop;
  assign ramp_level = st_reg.level;

  // ==========================================
  // Checks
  a_enable_pin_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !en_pin |=> !converter_on)
    else $error("converter on with enable pin low");
  a_read_stored_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (en_pin && reg_rd && reg_addr == 8'h02 && !reg_wr) |=> reg_rdata == $past(st_reg.fields))
    else $error("read data differs from stored value");
  a_write_takes_effect: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (en_pin && reg_wr && reg_addr == 8'h02) |=> freq_code == $past(reg_wdata[5:4]))
    else $error("frequency field not written");
  a_ton_follows_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (freq_code == 2'b11 && $stable(freq_code)) |=> on_time_cyc == 16'h0008)
    else $error("on-time not from frequency code");
  a_no_discharge_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (converter_on && !run_req && !st_reg.fields.soft_stop) |=> !discharge_active)
    else $error("discharge with soft stop clear");
  a_ramp_starts: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (converter_on && !run_req && st_reg.fields.soft_stop) |=> discharge_active)
    else $error("soft stop ramp not started");
  a_ramp_monotonic: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (discharge_active && $past(discharge_active)) |-> ramp_level <= $past(ramp_level))
    else $error("ramp level rose during discharge");
  a_limit_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ilim_sel.peak_en && ilim_sel.valley_en && ilim_sel.code == st_reg.fields.ilim_code)
    else $error("limit code not on both thresholds");
  a_filter_delay_30: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_reg.fields.filt_code == 2'b11) |-> delay_cyc == CW'(300))
    else $error("wrong deglitch count");
  a_good_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(raw_good) && delay_cyc == CW'(60) && !power_good_output) |=> !power_good_output)
    else $error("power good rose without delay");
endmodule : sys_control2_pgood_filter

// ### shared/sys_ctrl2_defs.svh
// Offsets, field positions, reset values and timing counts of the second control register
`ifndef SYS_CTRL2_DEFS_SVH
`define SYS_CTRL2_DEFS_SVH
`define SC2_OFFSET 8'h02
`define SC2_RESET 8'hC1
`define SC2_FILT_MSB 7
`define SC2_FILT_LSB 6
`define SC2_FREQ_MSB 5
`define SC2_FREQ_LSB 4
`define SC2_SSTOP_BIT 3
`define SC2_ILIM_MSB 2
`define SC2_ILIM_LSB 0
`define SC2_CLK_MHZ 10
`define SC2_DLY0_US 1
`define SC2_DLY1_US 6
`define SC2_DLY2_US 12
`define SC2_DLY3_US 30
`define SC2_DLY0_CYC 9
`define SC2_DLY1_CYC (`SC2_DLY1_US * `SC2_CLK_MHZ)
`define SC2_DLY2_CYC (`SC2_DLY2_US * `SC2_CLK_MHZ)
`define SC2_DLY3_CYC (`SC2_DLY3_US * `SC2_CLK_MHZ)
`define SC2_TON_500K 16'h0014
`define SC2_TON_750K 16'h000D
`define SC2_TON_1M 16'h000A
`define SC2_TON_1M25 16'h0008
`define SC2_STOP_STEP 16'h000A
`endif

// ### shared/sys_ctrl2_pkg.sv
// Types of the second control register block
package sys_ctrl2_pkg;
  typedef struct packed {
    logic [1:0] filt_code;
    logic [1:0] freq_code;
    logic soft_stop;
    logic [2:0] ilim_code;
  } ctrl2_fields_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RAMP = 2'b01,
    ST_OFF = 2'b10
  } stop_state_t;
  typedef struct packed {
    logic peak_en;
    logic valley_en;
    logic [2:0] code;
  } ilim_sel_t;
endpackage : sys_ctrl2_pkg

// ### src/good_flag_filter.sv
// Deglitch timer that delays both edges of the power-good indication
`timescale 1ns/100ps
`include "sys_ctrl2_defs.svh"
module good_flag_filter #(
  parameter int CW = 12
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic raw_in,
  input wire logic [CW-1:0] delay_cyc,
  output logic filt_out
);
  typedef struct packed {
    logic out;
    logic [CW-1:0] cnt;
  } filt_state_t;
  filt_state_t st_reg;
  filt_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (raw_in == st_reg.out)
    begin
      st_next.cnt = '0;
    end
    else if (st_reg.cnt + CW'(1) >= delay_cyc)
    begin
      st_next.out = raw_in;
      st_next.cnt = '0;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign filt_out = st_reg.out;

  a_filter_no_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(filt_out) |-> $past(raw_in) == filt_out)
    else $error("power good changed against raw level");
endmodule : good_flag_filter

// ### verif/reg_master.sv
// Register bus master model driving the control register port
`timescale 1ns/100ps
module reg_master (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // =========================
  // Bus cycles, idle lines toggled
  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 4 && !ok; i++)
      begin
        if (reg_rvalid === 1'b1)
        begin
          ok = 1'b1;
          d = reg_rdata;
        end
        else
          @(negedge clk_sys);
      end
    end
  endtask : rd
endmodule : reg_master

// ### verif/test_sys_control2_pgood_filter.sv
// Self-checking bench of the second control register block
`timescale 1ns/100ps
module test_sys_control2_pgood_filter;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic en_pin = 1'b1;
  logic sw_enable = 1'b1;
  logic ov_trip = 1'b0;
  logic uv_trip = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, good_out, conv_on, bus_on, dis_on, floating, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, lvl, rd_v;
  logic [15:0] on_time;
  logic [1:0] freq;
  sys_ctrl2_pkg::ilim_sel_t ilim;
  int num_errors = 0;
  int total_checks = 0;
  int model;
  int ton[4] = '{20, 13, 10, 8};
  int dly[4] = '{9, 60, 120, 300};
  always #50 clk_sys = ~clk_sys;
  sys_control2_pgood_filter dut_u (.clk_sys(clk_sys), .rstn(rstn), .en_pin(en_pin),
    .sw_enable(sw_enable), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .over_voltage_trip(ov_trip), .under_voltage_trip(uv_trip), .power_good_output(good_out),
    .on_time_cyc(on_time), .freq_code(freq), .ilim_sel(ilim), .converter_on(conv_on),
    .bus_active(bus_on), .discharge_active(dis_on), .output_floating(floating),
    .ramp_level(lvl));
  reg_master pm_u (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  // =========================
  // Compare and report
  task end_sim;
    begin
      if (num_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask : end_sim
  task chk_v(input logic [15:0] got, input logic [15:0] exp);
    begin
      total_checks++;
      if (got !== exp)
      begin
        num_errors++;
        $display("BAD %0t value %h expected %h", $time, got, exp);
      end
    end
  endtask : chk_v
  task chk_n(input int n, input int lo, input int hi);
    begin
      total_checks++;
      if (n < lo || n > hi)
      begin
        num_errors++;
        $display("BAD %0t count %0d outside %0d..%0d", $time, n, lo, hi);
        end_sim();
      end
    end
  endtask : chk_n
  task rd_chk(input logic [7:0] a, input int exp);
    begin
      pm_u.rd(a, rd_v, ok);
      chk_v(ok, 1'b1);
      if (ok !== 1'b1)
        end_sim();
      chk_v(rd_v, 16'(exp & 8'hFF));
    end
  endtask : rd_chk
  task good_meas(input int c);
    int n;
    begin
      pm_u.wr(8'h02, 8'(c << 6) | 8'h01);
      {ov_trip, uv_trip} = 2'b11;
      repeat (dly[c] / 2) @(negedge clk_sys);
      {ov_trip, uv_trip} = 2'b00;
      // Let the filter see the good level so the short trip is cleared
      @(negedge clk_sys);
      chk_v(good_out, 1'b1);
      for (int e = 0; e < 2; e++)
      begin
        {ov_trip, uv_trip} = e ? 2'b00 : (c[0] ? 2'b10 : 2'b01);
        n = 0;
        while (good_out !== e[0] && n < 400)
        begin
          @(negedge clk_sys);
          n++;
        end
        chk_n(n, dly[c] - 1, dly[c] + 2);
      end
    end
  endtask : good_meas
  // =========================
  // Main sequence
  initial
  begin
    void'($urandom(31));
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    model = 8'hC1;
    rd_chk(8'h02, model);
    chk_v(on_time, 16'h0014);
    chk_v(ilim, 5'b11001);
    for (int f = 0; f < 4; f++)
    begin
      model = ($urandom & 8'hCF) | (f << 4);
      pm_u.wr(8'h02, 8'(model));
      rd_chk(8'h02, model);
      chk_v(freq, 16'(f));
      chk_v(on_time, 16'(ton[f]));
      chk_v(ilim, {2'b11, 3'(model)});
    end
    pm_u.wr(8'h05, 8'h3C);
    rd_chk(8'h05, 0);
    rd_chk(8'h02, model);
    repeat (400) @(negedge clk_sys);
    for (int c = 0; c < 4; c++)
      good_meas(c);
    en_pin = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_v({conv_on, bus_on, dis_on, floating}, 4'b0001);
    pm_u.rd(8'h02, rd_v, ok);
    chk_v(ok, 1'b0);
    en_pin = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_v({conv_on, bus_on}, 2'b11);
    pm_u.wr(8'h02, 8'hC9);
    sw_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_v({conv_on, dis_on}, 2'b01);
    model = lvl;
    repeat (100) @(negedge clk_sys);
    chk_v(lvl, 16'((model - 10) & 8'hFF));
    model = 0;
    while (dis_on !== 1'b0 && model < 3000)
    begin
      @(negedge clk_sys);
      model++;
    end
    chk_n(model, 0, 2999);
    chk_v(conv_on, 1'b0);
    end_sim();
  end
endmodule : test_sys_control2_pgood_filter
